//--- driver_termination_power_config.sv
// driver strength, input termination and power-saving configuration words
`timescale 1ns/1ps
`include "dtpc_consts.svh"
module driver_termination_power_config
    import dtpc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_word_wr,
    input wire word_wr_s i_word,
    input wire logic i_mirror,
    input wire logic i_clock_enable_in_0,
    input wire logic i_clock_enable_in_1,
    input wire logic [1:0] i_odt_in_pair,
    output drive_set_s o_drive,
    output term_s o_input_termination,
    output logic o_prelaunch_ca,
    output logic o_three_t,
    output idle_mode_e o_ca_idle_mode,
    output logic o_ca_float_en,
    output logic o_power_down_enable,
    output logic o_powered_down,
    output logic [1:0] o_odt_out
);

    // decode one drive pair; reserved codes keep the setting held so far
    // the refusal is per pair, so a word with one reserved pair still
    // updates the other pair and software need not read anything back
    function automatic drive_e decode_drive(
        input logic [1:0] code,
        input logic allow_strong,
        input drive_e held
    );
        drive_e result;
        result = held;
        case (code)
            2'h0: result = DRV_LIGHT;
            2'h1: result = DRV_MODERATE;
            2'h2: result = allow_strong ? DRV_STRONG : held;
            default: result = held;
        endcase
        return result;
    endfunction : decode_drive

    // true when a write strobe targets the given word
    function automatic logic word_hit(
        input logic wr,
        input logic [3:0] index,
        input logic [3:0] want
    );
        return wr && (index == want);
    endfunction : word_hit

    // pins arrive from outside the clock domain
    // the sync flops clear on reset, so the clock enables read low for two
    // cycles afterwards; power-down is disabled by reset, so no false entry
    // follows, and the odt output reads low meanwhile through its cleared sync flops
    logic mirror_s;
    logic [1:0] cke_s;
    logic [1:0] odt_s;

    pin_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async({i_mirror, i_clock_enable_in_1, i_clock_enable_in_0, i_odt_in_pair}),
        .o_sync({mirror_s, cke_s, odt_s})
    );

    // stored words and decoded settings
    // only the float bit of the global word is kept; the rest is not served here
    logic float_en_r;
    logic float_en_nxt;
    logic timing_prelaunch_r;
    logic timing_prelaunch_nxt;
    logic timing_three_t_r;
    logic timing_three_t_nxt;
    logic timing_term150_r;
    logic timing_term150_nxt;
    logic [3:0] extra_term_r;
    logic [3:0] extra_term_nxt;
    logic [3:0] power_saving_r;
    logic [3:0] power_saving_nxt;
    drive_set_s drive_r;
    drive_set_s drive_nxt;

    // one strobe per known word; other indexes are ignored on purpose
    logic wr_global;
    logic wr_timing;
    logic wr_ca;
    logic wr_ctl;
    logic wr_clk;
    logic wr_xterm;
    logic wr_pwr;

    assign wr_global = word_hit(i_word_wr, i_word.index, `WORD_GLOBAL_FEATURES);
    assign wr_timing = word_hit(i_word_wr, i_word.index, `WORD_TIMING);
    assign wr_ca = word_hit(i_word_wr, i_word.index, `WORD_ADDR_CMD_DRIVE);
    assign wr_ctl = word_hit(i_word_wr, i_word.index, `WORD_CONTROL_DRIVE);
    assign wr_clk = word_hit(i_word_wr, i_word.index, `WORD_CLOCK_DRIVE);
    assign wr_xterm = word_hit(i_word_wr, i_word.index, `WORD_EXTRA_TERMINATION);
    assign wr_pwr = word_hit(i_word_wr, i_word.index, `WORD_POWER_SAVING);

    // next values of the configuration state; untouched words hold
    // back-to-back writes to different words are all taken, one per cycle
    always_comb begin
        float_en_nxt = float_en_r;
        timing_prelaunch_nxt = timing_prelaunch_r;
        timing_three_t_nxt = timing_three_t_r;
        timing_term150_nxt = timing_term150_r;
        extra_term_nxt = extra_term_r;
        power_saving_nxt = power_saving_r;
        drive_nxt = drive_r;
        if (wr_global) begin
            float_en_nxt = i_word.data[`GLOBAL_FLOAT_BIT];
        end
        if (wr_timing) begin
            timing_prelaunch_nxt = i_word.data[`TIMING_PRELAUNCH_BIT];
            timing_three_t_nxt = i_word.data[`TIMING_THREE_T_BIT];
            timing_term150_nxt = i_word.data[`TIMING_TERM150_BIT];
        end
        if (wr_ca) begin
            drive_nxt.ca_a = decode_drive(i_word.data[`DRIVE_LOW_LSB +: 2], 1'b1, drive_r.ca_a);
            drive_nxt.ca_b = decode_drive(i_word.data[`DRIVE_HIGH_LSB +: 2], 1'b1, drive_r.ca_b);
        end
        if (wr_ctl) begin
            drive_nxt.ctl_a = decode_drive(i_word.data[`DRIVE_LOW_LSB +: 2], 1'b0, drive_r.ctl_a);
            drive_nxt.ctl_b = decode_drive(i_word.data[`DRIVE_HIGH_LSB +: 2], 1'b0, drive_r.ctl_b);
        end
        if (wr_clk) begin
            drive_nxt.clk_odd = decode_drive(i_word.data[`DRIVE_LOW_LSB +: 2], 1'b1,
                drive_r.clk_odd);
            drive_nxt.clk_even = decode_drive(i_word.data[`DRIVE_HIGH_LSB +: 2], 1'b1,
                drive_r.clk_even);
        end
        if (wr_xterm) begin
            extra_term_nxt = i_word.data;
        end
        if (wr_pwr) begin
            power_saving_nxt = i_word.data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            float_en_r <= 1'b0;
            timing_prelaunch_r <= 1'b0;
            timing_three_t_r <= 1'b0;
            timing_term150_r <= 1'b0;
            extra_term_r <= `RESET_WORD;
            power_saving_r <= `RESET_WORD;
            drive_r <= '{DRV_LIGHT, DRV_LIGHT, DRV_LIGHT, DRV_LIGHT, DRV_LIGHT, DRV_LIGHT};
        end else begin
            float_en_r <= float_en_nxt;
            timing_prelaunch_r <= timing_prelaunch_nxt;
            timing_three_t_r <= timing_three_t_nxt;
            timing_term150_r <= timing_term150_nxt;
            extra_term_r <= extra_term_nxt;
            power_saving_r <= power_saving_nxt;
            drive_r <= drive_nxt;
        end
    end

    // power-down sequencing lives in its own small machine
    // the pins feeding it are already synchronised, so it adds one edge
    logic powered_down;
    logic pd_enable;

    assign pd_enable = power_saving_r[`PWR_ENABLE_BIT];

    power_down_ctl u_power_down_ctl (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_enable(pd_enable),
        .i_cke_0(cke_s[0]),
        .i_cke_1(cke_s[1]),
        .o_powered_down(powered_down)
    );

    // the mode bit only matters while powered down
    logic pd_term_off;
    assign pd_term_off = powered_down && power_saving_r[`PWR_MODE_BIT];

    // effective termination, computed from the words and the pins
    // priority, strongest first: power-down mode one, code 111, mirror high
    // with any low code bit set, mirror high with code 000, then plain codes
    term_s term_nxt;
    term_s term_r;
    logic [2:0] xcode;
    assign xcode = extra_term_r[2:0];

    always_comb begin
        term_nxt.main_en = 1'b1;
        term_nxt.cs_odt_en = 1'b1;
        term_nxt.value = timing_term150_r ? TERM_150 : TERM_100;
        // resistance codes; reserved codes fall back to the timing word
        case (xcode)
            `XTERM_CODE_200: term_nxt.value = TERM_200;
            `XTERM_CODE_300: term_nxt.value = TERM_300;
            default: term_nxt.value = timing_term150_r ? TERM_150 : TERM_100;
        endcase
        if (xcode == `XTERM_CODE_OFF) begin
            term_nxt.main_en = 1'b0;
            term_nxt.cs_odt_en = 1'b0;
        end else if (mirror_s && (xcode != `XTERM_CODE_FOLLOW)) begin
            term_nxt.main_en = 1'b0;
            term_nxt.cs_odt_en = 1'b0;
        end else if (mirror_s) begin
            term_nxt.main_en = extra_term_r[`XTERM_MIRROR_ON_BIT];
            term_nxt.cs_odt_en = 1'b1;
        end
        if (pd_term_off) begin
            term_nxt.main_en = 1'b0;
            term_nxt.cs_odt_en = 1'b0;
        end
    end

    // idle behaviour of the address/command outputs
    // floating and weak drive both need the float bit; with it clear the
    // address/command outputs are driven in every cycle
    idle_mode_e idle_nxt;
    idle_mode_e idle_r;
    logic float_nxt;
    logic float_r;

    always_comb begin
        // 3T timing drives every cycle, so there is nothing left to float
        float_nxt = float_en_r && !timing_three_t_r;
        idle_nxt = IDLE_DRIVE;
        if (float_nxt) begin
            idle_nxt = power_saving_r[`PWR_WEAK_BIT] ? IDLE_WEAK : IDLE_FLOAT;
        end
    end

    // odt passthrough, forced low in the termination-off power-down mode
    // odt trails its pin by three edges: two sync flops and the pad register
    logic [1:0] odt_nxt;
    logic [1:0] odt_r;

    always_comb begin
        odt_nxt = pd_term_off ? 2'h0 : odt_s;
    end

    // registered pad codes so the pads never see decode glitches
    // reset codes match power-up: termination on at 100 ohm, bus driven
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            term_r <= '{1'b1, 1'b1, TERM_100};
            idle_r <= IDLE_DRIVE;
            float_r <= 1'b0;
            odt_r <= 2'h0;
        end else begin
            term_r <= term_nxt;
            idle_r <= idle_nxt;
            float_r <= float_nxt;
            odt_r <= odt_nxt;
        end
    end

    assign o_drive = drive_r;
    assign o_input_termination = term_r;
    assign o_ca_idle_mode = idle_r;
    assign o_ca_float_en = float_r;
    assign o_odt_out = odt_r;
    assign o_prelaunch_ca = timing_prelaunch_r;
    assign o_three_t = timing_three_t_r;
    assign o_power_down_enable = pd_enable;
    assign o_powered_down = powered_down;

endmodule : driver_termination_power_config

//--- dtpc_consts.svh
// constants for the driver, termination and power-saving configuration block
`ifndef DTPC_CONSTS_SVH
`define DTPC_CONSTS_SVH

// configuration word indexes, as carried on the command/address inputs
`define WORD_GLOBAL_FEATURES 4'h0
`define WORD_TIMING 4'h2
`define WORD_ADDR_CMD_DRIVE 4'h3
`define WORD_CONTROL_DRIVE 4'h4
`define WORD_CLOCK_DRIVE 4'h5
`define WORD_EXTRA_TERMINATION 4'h8
`define WORD_POWER_SAVING 4'h9

// global features word fields
`define GLOBAL_FLOAT_BIT 1

// timing word fields
`define TIMING_PRELAUNCH_BIT 0
`define TIMING_THREE_T_BIT 1
`define TIMING_TERM150_BIT 2

// drive words: low pair and high pair
`define DRIVE_LOW_LSB 0
`define DRIVE_HIGH_LSB 2

// extra termination word fields
`define XTERM_MIRROR_ON_BIT 3
`define XTERM_CODE_FOLLOW 3'h0
`define XTERM_CODE_200 3'h2
`define XTERM_CODE_300 3'h4
`define XTERM_CODE_OFF 3'h7

// power saving word fields
`define PWR_WEAK_BIT 0
`define PWR_MODE_BIT 2
`define PWR_ENABLE_BIT 3

// reset values of the stored words
`define RESET_WORD 4'h0

`endif

//--- dtpc_pkg.sv
// types shared by the driver, termination and power-saving configuration block
package dtpc_pkg;

    typedef enum logic [1:0] {
        DRV_LIGHT = 2'h0,
        DRV_MODERATE = 2'h1,
        DRV_STRONG = 2'h2
    } drive_e;

    typedef enum logic [1:0] {
        TERM_100 = 2'h0,
        TERM_150 = 2'h1,
        TERM_200 = 2'h2,
        TERM_300 = 2'h3
    } term_value_e;

    typedef enum logic [1:0] {
        IDLE_DRIVE = 2'h0,
        IDLE_FLOAT = 2'h1,
        IDLE_WEAK = 2'h2
    } idle_mode_e;

    typedef enum logic {
        PD_ACTIVE = 1'b0,
        PD_DOWN = 1'b1
    } pd_state_e;

    typedef struct packed {
        logic [3:0] index;
        logic [3:0] data;
    } word_wr_s;

    typedef struct packed {
        drive_e ca_a;
        drive_e ca_b;
        drive_e ctl_a;
        drive_e ctl_b;
        drive_e clk_odd;
        drive_e clk_even;
    } drive_set_s;

    typedef struct packed {
        logic main_en;
        logic cs_odt_en;
        term_value_e value;
    } term_s;

endpackage : dtpc_pkg

//--- pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    // a zero-width group has nothing to synchronise; refuse it at elaboration
    if (WIDTH < 1) begin : g_width_check
        $error("pin_sync: WIDTH must be at least 1");
    end

    // one pair of flops per bit; the first flop feeds only the second
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta_r;
            logic sync_r;
            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= i_async[g];
                    sync_r <= meta_r;
                end
            end
            assign o_sync[g] = sync_r;
        end
    endgenerate
endmodule : pin_sync

//--- power_down_ctl.sv
// clock-enable power-down state machine
`timescale 1ns/1ps
module power_down_ctl
    import dtpc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic i_cke_0,
    input wire logic i_cke_1,
    output logic o_powered_down
);
    pd_state_e state_r;
    pd_state_e state_nxt;

    // enter when both clock enables are low, leave when either rises
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PD_ACTIVE: begin
                if (i_enable && !i_cke_0 && !i_cke_1) begin
                    state_nxt = PD_DOWN;
                end
            end
            PD_DOWN: begin
                // disabling the feature also ends power-down at once
                if (!i_enable || i_cke_0 || i_cke_1) begin
                    state_nxt = PD_ACTIVE;
                end
            end
            default: begin
                state_nxt = PD_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_r <= PD_ACTIVE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_powered_down = (state_r == PD_DOWN);
endmodule : power_down_ctl

//--- driver_termination_power_config_props.sv
// assertions on the configuration word block ports
`timescale 1ns/1ps
module driver_termination_power_config_props
    import dtpc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_word_wr,
    input wire word_wr_s i_word,
    input wire logic i_mirror,
    input wire logic i_clock_enable_in_0,
    input wire logic i_clock_enable_in_1,
    input wire logic [1:0] i_odt_in_pair,
    input wire drive_set_s o_drive,
    input wire term_s o_input_termination,
    input wire logic o_prelaunch_ca,
    input wire logic o_three_t,
    input wire idle_mode_e o_ca_idle_mode,
    input wire logic o_ca_float_en,
    input wire logic o_power_down_enable,
    input wire logic o_powered_down,
    input wire logic [1:0] o_odt_out
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic [3:0] d;
    logic wr3, wr4, wr5, wr8, wr9;
    logic [2:0] mode_r;
    logic [2:0] mode_nxt;
    // word strobes decoded per index
    assign d = i_word.data;
    assign wr3 = i_word_wr && i_word.index == 4'h3;
    assign wr4 = i_word_wr && i_word.index == 4'h4;
    assign wr5 = i_word_wr && i_word.index == 4'h5;
    assign wr8 = i_word_wr && i_word.index == 4'h8;
    assign wr9 = i_word_wr && i_word.index == 4'h9;
    // last power-down mode bit, aged so the slower termination path has settled
    always_comb begin
        mode_nxt = {mode_r[1:0], wr9 ? d[2] : mode_r[0]};
    end
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mode_r <= 3'h0;
        end else begin
            mode_r <= mode_nxt;
        end
    end
    a_ca_side_a:
    assert property (wr3 && d[1:0] != 2'h3 |=> o_drive.ca_a == $past(d[1:0]))
        else $error("address drive A not applied");
    a_ca_side_b:
    assert property (wr3 && d[3:2] != 2'h3 |=> o_drive.ca_b == $past(d[3:2]))
        else $error("address drive B not applied");
    a_ctl_reserved_hold:
    assert property (wr4 && d[1] |=> $stable(o_drive.ctl_a))
        else $error("reserved control drive code changed side A");
    a_clk_even_pair:
    assert property (wr5 && d[3:2] != 2'h3 |=> o_drive.clk_even == $past(d[3:2]))
        else $error("clocks 0 and 2 drive not from high pair");
    a_pd_enable_bit:
    assert property (wr9 |=> o_power_down_enable == $past(d[3]))
        else $error("power-down enable not taken from bit three");
    a_pd_entry:
    assert property ((o_power_down_enable && !i_clock_enable_in_0
        && !i_clock_enable_in_1) [*4] |-> o_powered_down)
        else $error("power-down not entered with both clock enables low");
    a_pd_gated_off:
    assert property (!o_power_down_enable [*2] |-> !o_powered_down)
        else $error("power-down while disabled");
    a_pd_odt_low:
    assert property ((o_powered_down && (&mode_r)) [*2] |-> o_odt_out == 2'h0
        && !o_input_termination.main_en && !o_input_termination.cs_odt_en)
        else $error("power-down mode one left termination or odt on");
    a_xterm_all_off:
    assert property (wr8 && d[2:0] == 3'h7 ##1 !wr8 |=> !o_input_termination.main_en
        && !o_input_termination.cs_odt_en)
        else $error("termination off code did not clear all inputs");
endmodule : driver_termination_power_config_props

bind driver_termination_power_config driver_termination_power_config_props props_u (
    .i_clock(i_clock), .i_rst(i_rst), .i_word_wr(i_word_wr), .i_word(i_word),
    .i_mirror(i_mirror), .i_clock_enable_in_0(i_clock_enable_in_0),
    .i_clock_enable_in_1(i_clock_enable_in_1), .i_odt_in_pair(i_odt_in_pair),
    .o_drive(o_drive), .o_input_termination(o_input_termination),
    .o_prelaunch_ca(o_prelaunch_ca), .o_three_t(o_three_t),
    .o_ca_idle_mode(o_ca_idle_mode), .o_ca_float_en(o_ca_float_en),
    .o_power_down_enable(o_power_down_enable), .o_powered_down(o_powered_down),
    .o_odt_out(o_odt_out));

//--- dtpc_ctl_model.sv
// controller-side model that writes configuration words
`timescale 1ns/1ps
module dtpc_ctl_model
    import dtpc_pkg::*;
(
    input wire logic i_clock,
    output logic o_word_wr,
    output word_wr_s o_word
);
    // bus idle at time zero
    initial begin
        o_word_wr = 1'b0;
        o_word = 8'h00;
    end
    // one-cycle strobe; gap gives a slow controller, released bus shows no stale word
    task automatic put(input logic [3:0] idx, input logic [3:0] dat, input int gap);
        repeat (gap) @(posedge i_clock);
        @(posedge i_clock);
        o_word_wr <= 1'b1;
        o_word <= {idx, dat};
        @(posedge i_clock);
        o_word_wr <= 1'b0;
        o_word <= ~{idx, dat};
    endtask : put
endmodule : dtpc_ctl_model

//--- driver_termination_power_config_tb.sv
// self-checking bench for the configuration word block
`timescale 1ns/1ps
module driver_termination_power_config_tb
    import dtpc_pkg::*;
();
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic mirror = 1'b0;
    logic cke0 = 1'b1;
    logic cke1 = 1'b1;
    logic [1:0] odt_in = 2'h0;
    logic word_wr;
    word_wr_s word;
    drive_set_s drive;
    term_s term;
    idle_mode_e idle_mode;
    logic prelaunch, three_t, float_en, pd_en, pd;
    logic [1:0] odt_out;
    int errors = 0;
    int cmp_count = 0;
    logic [1:0] prev;
    logic [8:0] tcase [10];
    // free-running clock at 100 MHz
    always #5 i_clock = ~i_clock;
    dtpc_ctl_model wr_u (.i_clock(i_clock), .o_word_wr(word_wr), .o_word(word));
    driver_termination_power_config dut_u (
        .i_clock(i_clock), .i_rst(i_rst), .i_word_wr(word_wr), .i_word(word),
        .i_mirror(mirror), .i_clock_enable_in_0(cke0), .i_clock_enable_in_1(cke1),
        .i_odt_in_pair(odt_in), .o_drive(drive), .o_input_termination(term),
        .o_prelaunch_ca(prelaunch), .o_three_t(three_t), .o_ca_idle_mode(idle_mode),
        .o_ca_float_en(float_en), .o_power_down_enable(pd_en), .o_powered_down(pd),
        .o_odt_out(odt_out));
    // compare and count
    task automatic chk(input string what, input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // let n edges land, then step off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : settle
    // write a word and wait until even the pin-delayed outputs follow
    task automatic wr(input logic [3:0] idx, input logic [3:0] dat);
        wr_u.put(idx, dat, 0);
        settle(3);
    endtask : wr
    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    // a hang costs at most a few thousand cycles; the tests take a few hundred
    initial begin
        repeat (5000) @(posedge i_clock);
        errors++;
        close_out();
    end
    // mirror, extra word, expected {main, cs/odt} and value
    initial begin
        tcase = '{{1'b0, 4'h2, 2'b11, TERM_200}, {1'b0, 4'h4, 2'b11, TERM_300},
            {1'b0, 4'h7, 2'b00, TERM_100}, {1'b1, 4'h7, 2'b00, TERM_100},
            {1'b1, 4'h0, 2'b01, TERM_100}, {1'b1, 4'h8, 2'b11, TERM_100},
            {1'b1, 4'hA, 2'b00, TERM_100}, {1'b1, 4'hC, 2'b00, TERM_100},
            {1'b0, 4'h1, 2'b11, TERM_100}, {1'b1, 4'h3, 2'b00, TERM_100}};
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        settle(1);
        chk("drive", drive, 12'h000);
        chk("term", term, {2'b11, TERM_100});
        chk("pd_en", pd_en, 1'b0);
        prev = 2'h0;
        for (int c = 0; c < 4; c++) begin
            wr(4'h3, {c[1:0], c[1:0]});
            prev = (c == 3) ? prev : c[1:0];
            chk("ca", {drive.ca_b, drive.ca_a}, {prev, prev});
        end
        for (int c = 0; c < 4; c++) begin
            wr(4'h4, {c[1:0], c[1:0]});
            prev = (c > 1) ? prev : c[1:0];
            chk("ctl", {drive.ctl_b, drive.ctl_a}, {prev, prev});
        end
        wr(4'h5, 4'h6);
        chk("clk", {drive.clk_even, drive.clk_odd}, {DRV_MODERATE, DRV_STRONG});
        wr(4'h5, 4'hB);
        chk("clk", {drive.clk_even, drive.clk_odd}, {DRV_STRONG, DRV_STRONG});
        wr(4'h2, 4'h5);
        chk("pre", prelaunch, 1'b1);
        chk("t150", term, {2'b11, TERM_150});
        wr(4'h2, 4'h0);
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clock);
            mirror <= tcase[i][8];
            wr(4'h8, tcase[i][7:4]);
            chk("term", term[3:2], tcase[i][3:2]);
            if (tcase[i][3]) chk("tval", term.value, tcase[i][1:0]);
        end
        @(posedge i_clock);
        mirror <= 1'b0;
        wr(4'h8, 4'h0);
        wr(4'h0, 4'h2);
        wr(4'h9, 4'h1);
        chk("idle", idle_mode, IDLE_WEAK);
        chk("float", float_en, 1'b1);
        wr(4'h9, 4'h0);
        chk("idle", idle_mode, IDLE_FLOAT);
        // 3T timing leaves nothing to float, even with the float bit set
        wr(4'h2, 4'h2);
        chk("three_t", three_t, 1'b1);
        chk("pre", prelaunch, 1'b0);
        chk("float", float_en, 1'b0);
        chk("idle", idle_mode, IDLE_DRIVE);
        wr(4'h2, 4'h0);
        chk("idle", idle_mode, IDLE_FLOAT);
        @(posedge i_clock);
        cke0 <= 1'b0;
        cke1 <= 1'b0;
        settle(6);
        chk("pd", pd, 1'b0);
        wr(4'h9, 4'h8);
        chk("pd_en", pd_en, 1'b1);
        @(posedge i_clock);
        odt_in <= 2'h2;
        settle(4);
        chk("pd", pd, 1'b1);
        chk("odt", {term.main_en, odt_out}, 3'h6);
        wr_u.put(4'h9, 4'hC, 3);
        settle(3);
        chk("odt", {term[3:2], odt_out}, 4'h0);
        @(posedge i_clock);
        cke0 <= 1'b1;
        settle(5);
        chk("pd", pd, 1'b0);
        @(posedge i_clock);
        cke0 <= 1'b0;
        wr(4'h9, 4'h4);
        settle(3);
        chk("pd", pd, 1'b0);
        // a reset in mid-run must bring every held setting back to power-up
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        settle(1);
        chk("drive", drive, 12'h000);
        chk("idle", idle_mode, IDLE_DRIVE);
        chk("float", float_en, 1'b0);
        chk("pd_en", pd_en, 1'b0);
        close_out();
    end
endmodule : driver_termination_power_config_tb
